// ==== core/pcc_pkg.sv ====
// constants, field layouts and state types of the clock control block
// assumes one 200 MHz system clock and tick inputs synchronous to it

package pcc_pkg;

	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [3:0] PCC_OFS_CTRL = 4'h0;
	localparam logic [3:0] PCC_OFS_CNT  = 4'h4;
	localparam logic [3:0] PCC_OFS_STAT = 4'h8;

	// ---------------------------------------------------------------
	// counter values
	// ---------------------------------------------------------------
	localparam logic [7:0] PCC_PRE_LOAD = 8'hff;
	localparam logic [7:0] PCC_TMR_LOAD = 8'h01;
	localparam logic [3:0] PCC_OSC_LAST = 4'hf;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PCC_RUN,
		PCC_WAIT,
		PCC_STOP,
		PCC_REL
	} pcc_mode_t;

	// control register, bit 0 at the bottom of the list
	typedef struct packed {
		logic [1:0] pll_mode;
		logic       stab_sel;
		logic [1:0] sys_div;
		logic [1:0] usb_div;
		logic       sys_sel;
		logic       syn_src;
		logic       usb_sel;
		logic       pll_en;
	} pcc_cfg_t;

	localparam pcc_cfg_t PCC_CFG_RST = '0;

	typedef struct packed {
		pcc_cfg_t    cfg;
		logic        act_sel;
		logic [1:0]  act_div;
		pcc_mode_t   mode;
		logic        stop_pend;
		logic        wait_pend;
		logic        cpu_clk;
		logic        osc_on;
		logic [3:0]  half_cnt;
		logic [3:0]  syn_cnt;
		logic        syn_tick;
		logic        usb_tick;
		logic [3:0]  osc_cnt;
		logic [7:0]  pre;
		logic [7:0]  tmr;
		logic        ack;
		logic [31:0] rdata;
	} pcc_st_t;

	localparam pcc_st_t PCC_ST_RST = '{
		cfg:       PCC_CFG_RST,
		act_sel:   1'b0,
		act_div:   2'h0,
		mode:      PCC_RUN,
		stop_pend: 1'b0,
		wait_pend: 1'b0,
		cpu_clk:   1'b1,
		osc_on:    1'b1,
		half_cnt:  4'h0,
		syn_cnt:   4'h0,
		syn_tick:  1'b0,
		usb_tick:  1'b0,
		osc_cnt:   4'h0,
		pre:       PCC_PRE_LOAD,
		tmr:       PCC_TMR_LOAD,
		ack:       1'b0,
		rdata:     32'h0000_0000
	};

endpackage

// ==== core/pcc_clock_ctrl.sv ====
// clock control: synthesizer control, clock selection and division,
// stop and wait low power states, wake timing after stop
// assumes ref_tick and vco_tick are one-cycle pulses, one per source
// clock period, synchronous to clk_sys; registers over avalon-mm

`timescale 1ns/1ps
`default_nettype none

module pcc_clock_ctrl
	import pcc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// clock sources
	input  wire logic        ref_tick,
	input  wire logic        vco_tick,
	// cpu side
	input  wire logic        stop_instr,
	input  wire logic        wait_instr,
	input  wire logic        ext_irq,
	input  wire logic        irq_accept,
	// clock outputs
	output logic             pll_run,
	output logic [1:0]       pll_mode,
	output logic             osc_run,
	output logic             usb_clk,
	output logic             syn_clk,
	output logic             cpu_clk
);

	// ---------------------------------------------------------------
	// ratio tables
	// ---------------------------------------------------------------

	// last count of the synthesized divider: ratios 4, 6, 8, 8
	function automatic logic [3:0] usb_last_f(input logic [1:0] sel);
		logic [3:0] r;
		r = 4'h7;
		unique case (sel)
			2'h0: r = 4'h3;
			2'h1: r = 4'h5;
			2'h2: r = 4'h7;
			2'h3: r = 4'h7;
		endcase
		return r;
	endfunction

	// last count of a cpu half period: ratios 2, 4, 8, 16
	function automatic logic [3:0] sys_last_f(input logic [1:0] sel);
		logic [3:0] r;
		r = 4'h0;
		unique case (sel)
			2'h0: r = 4'h0;
			2'h1: r = 4'h1;
			2'h2: r = 4'h3;
			2'h3: r = 4'h7;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	pcc_st_t    q;
	pcc_st_t    d;
	logic       req;
	logic       vco_ok;
	logic       ref_ok;
	logic       usb_src;
	logic       syn_src;
	logic       sys_tick;
	logic [10:0] cfg_bits;

	assign req     = read | write;
	assign vco_ok  = vco_tick & q.cfg.pll_en;
	assign ref_ok  = ref_tick & q.osc_on;
	assign usb_src = q.cfg.usb_sel ? vco_ok : ref_ok;
	assign syn_src = q.cfg.syn_src ? vco_ok : ref_ok;
	assign sys_tick = q.act_sel ? q.syn_tick : ref_ok;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		cfg_bits = q.cfg;
		d.syn_tick = 1'b0;
		d.usb_tick = usb_src;

		// bus: one wait cycle, then answer
		d.ack = req & ~q.ack;
		if (req && !q.ack) begin
			d.rdata = 32'h0000_0000;
			if (address == PCC_OFS_CTRL) begin
				d.rdata[10:0] = q.cfg;
			end else if (address == PCC_OFS_CNT) begin
				d.rdata[15:0] = {q.tmr, q.pre};
			end else if (address == PCC_OFS_STAT) begin
				d.rdata[6:0] = {q.act_div, q.act_sel, q.osc_on,
					q.cpu_clk, q.mode};
			end
		end
		if (write && q.ack) begin
			if (address == PCC_OFS_CTRL) begin
				if (byteenable[0]) begin
					cfg_bits[7:0] = writedata[7:0];
				end
				if (byteenable[1]) begin
					cfg_bits[10:8] = writedata[10:8];
				end
				d.cfg = cfg_bits;
			end else if (address == PCC_OFS_CNT) begin
				// software preload for the settle time
				if (byteenable[0]) begin
					d.pre = writedata[7:0];
				end
				if (byteenable[1]) begin
					d.tmr = writedata[15:8];
				end
			end
		end

		// synthesized clock divider
		if (syn_src) begin
			if (q.syn_cnt >= usb_last_f(q.cfg.usb_div)) begin
				d.syn_cnt = 4'h0;
				d.syn_tick = 1'b1;
			end else begin
				d.syn_cnt = q.syn_cnt + 4'h1;
			end
		end

		// low power state machine and cpu clock
		unique case (q.mode)
			PCC_RUN: begin
				if (stop_instr) begin
					d.stop_pend = 1'b1;
				end
				if (wait_instr) begin
					d.wait_pend = 1'b1;
				end
				if (sys_tick) begin
					if (q.half_cnt >= sys_last_f(q.act_div)) begin
						d.half_cnt = 4'h0;
						d.cpu_clk = ~q.cpu_clk;
						if (!q.cpu_clk) begin
							// rising edge closes a full period
							d.act_sel = q.cfg.sys_sel;
							d.act_div = q.cfg.sys_div;
							if (d.stop_pend) begin
								d.mode = PCC_STOP;
								d.stop_pend = 1'b0;
								d.wait_pend = 1'b0;
								if (!q.cfg.stab_sel) begin
									d.pre = PCC_PRE_LOAD;
									d.tmr = PCC_TMR_LOAD;
								end
							end else if (d.wait_pend) begin
								d.mode = PCC_WAIT;
								d.wait_pend = 1'b0;
							end
						end
					end else begin
						d.half_cnt = q.half_cnt + 4'h1;
					end
				end
			end
			PCC_WAIT: begin
				// oscillator keeps running, clock held high
				if (irq_accept) begin
					d.mode = PCC_RUN;
					d.half_cnt = 4'h0;
				end
			end
			PCC_STOP: begin
				if (ext_irq) begin
					d.mode = PCC_REL;
					d.osc_cnt = 4'h0;
				end
			end
			PCC_REL: begin
				// prescaler fed by the raw clock over 16
				if (ref_ok) begin
					d.osc_cnt = q.osc_cnt + 4'h1;
					if (q.osc_cnt == PCC_OSC_LAST) begin
						if (q.pre == 8'h00) begin
							d.pre = PCC_PRE_LOAD;
							d.tmr = q.tmr - 8'h01;
							if (q.tmr == 8'h00) begin
								d.mode = PCC_RUN;
								d.half_cnt = 4'h0;
							end
						end else begin
							d.pre = q.pre - 8'h01;
						end
					end
				end
			end
		endcase

		d.osc_on = (d.mode != PCC_STOP);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= PCC_ST_RST;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign waitrequest = req & ~q.ack;
	assign readdata    = q.rdata;
	assign pll_run     = q.cfg.pll_en;
	assign pll_mode    = q.cfg.pll_mode;
	assign osc_run     = q.osc_on;
	assign usb_clk     = q.usb_tick;
	assign syn_clk     = q.syn_tick;
	assign cpu_clk     = q.cpu_clk;

endmodule

`default_nettype wire

// ==== verification/pcc_osc_model.sv ====
// oscillator and synthesizer model giving tick pulses
// all ticks stop while the oscillator is off, synthesizer ticks also while the synthesizer is off
`timescale 1ns/1ps
`default_nettype none
module pcc_osc_model (
	input  wire logic clk_sys,
	input  wire logic osc_run,
	input  wire logic pll_run,
	output logic      ref_tick = 1'h0,
	output logic      vco_tick = 1'h0
);
	logic [1:0] cnt_q = 2'h0;
	always @(posedge clk_sys) begin
		cnt_q <= cnt_q + {1'h0, osc_run};
		ref_tick <= osc_run & (cnt_q == 2'h3);
		vco_tick <= osc_run & pll_run & cnt_q[0];
	end
endmodule
`default_nettype wire

// ==== verification/pcc_clock_ctrl_props.sv ====
// port checker of the clock control block
// bound to the design from the testbench top
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_ctrl_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic stop_instr,
	input wire logic ext_irq,
	input wire logic osc_run,
	input wire logic syn_clk,
	input wire logic usb_clk,
	input wire logic cpu_clk
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_wake;
		!osc_run ##1 osc_run;
	endsequence
	AST_STOP_HI: assert property (!osc_run |-> cpu_clk)
		else $error("cpu clock low in stop");
	AST_STOP_EDGE: assert property ($fell(osc_run) |-> $rose(cpu_clk))
		else $error("stop entered off a high clock");
	AST_STOP_GO: assert property (stop_instr && osc_run |-> ##[1:64] !osc_run)
		else $error("stop not entered");
	AST_WAKE: assert property (!osc_run && ext_irq |=> osc_run)
		else $error("oscillator not restarted");
	AST_OSC_SRC: assert property ($rose(osc_run) |-> $past(ext_irq))
		else $error("oscillator restarted unasked");
	AST_HOLD: assert property (s_wake |-> cpu_clk [*8])
		else $error("cpu clock released early");
	AST_SYN_GAP: assert property (syn_clk |=> !syn_clk [*3])
		else $error("synthesized ticks too close");
	AST_CPU_STEADY: assert property ($changed(cpu_clk) |=> $stable(cpu_clk))
		else $error("short cpu clock phase");
	AST_USB_GAP: assert property (usb_clk |=> !usb_clk)
		else $error("usb ticks too close");
endmodule
`default_nettype wire

// ==== verification/tb_pcc_clock_ctrl.sv ====
// self-checking bench of the clock control block
// drives avalon-mm and cpu events; the model makes the ticks
`timescale 1ns/1ps
`default_nettype none
module tb_pcc_clock_ctrl;
	import pcc_pkg::*;
	logic        clk_sys = 1'h0, rst_n = 1'h0, read = 1'h0, write = 1'h0;
	logic        stop_instr = 1'h0, wait_instr = 1'h0;
	logic        ext_irq = 1'h0, irq_accept = 1'h0;
	logic [3:0]  address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, r;
	logic        waitrequest, ref_tick, vco_tick, pll_run, osc_run;
	logic        usb_clk, syn_clk, cpu_clk;
	logic [1:0]  pll_mode;
	logic [63:0] e, exp_q[$];
	int          error_cnt = 0, n_checks = 0, n;
	logic [7:0]  cfgs[7] = '{8'h00, 8'h40, 8'h0f, 8'h1f, 8'h2f, 8'hcf, 8'h09};
	int          halves[7] = '{4, 8, 8, 12, 16, 64, 16};
	initial forever #2.5 clk_sys = ~clk_sys;
	pcc_clock_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .ref_tick(ref_tick),
		.vco_tick(vco_tick), .stop_instr(stop_instr), .wait_instr(wait_instr),
		.ext_irq(ext_irq), .irq_accept(irq_accept), .pll_run(pll_run),
		.pll_mode(pll_mode), .osc_run(osc_run), .usb_clk(usb_clk),
		.syn_clk(syn_clk), .cpu_clk(cpu_clk));
	pcc_osc_model u_osc (.clk_sys(clk_sys), .osc_run(osc_run),
		.pll_run(pll_run), .ref_tick(ref_tick), .vco_tick(vco_tick));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk_sys);
		read <= rd;
		write <= ~rd;
		address <= a;
		writedata <= d;
		do @(negedge clk_sys); while (waitrequest !== 1'h0 && ++k < 50);
		@(posedge clk_sys);
		read <= 1'h0;
		write <= 1'h0;
		if (k == 50) error_cnt++;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
		exp_q.push_back({m, x & m});
		bus(1'h1, a, 32'h0);
	endtask
	// cycles of the last full cpu clock phase
	task automatic half(output int h);
		logic v;
		repeat (4) begin
			v = cpu_clk;
			h = 0;
			do begin
				@(negedge clk_sys);
				h++;
			end while (cpu_clk === v && h < 300);
		end
	endtask
	// stop, wake by interrupt, count cycles until the clock runs
	task automatic sleep(output int h);
		@(posedge clk_sys);
		stop_instr <= 1'h1;
		@(posedge clk_sys);
		stop_instr <= 1'h0;
		repeat (60) @(posedge clk_sys);
		ext_irq <= 1'h1;
		@(posedge clk_sys);
		ext_irq <= 1'h0;
		h = 0;
		do @(negedge clk_sys); while (cpu_clk === 1'h1 && ++h < 60000);
	endtask
	always @(negedge clk_sys)
		if (read === 1'h1 && waitrequest === 1'h0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check(readdata & e[63:32], e[31:0]);
		end
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
	initial begin
		void'($urandom(75707));
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'h1;
		rd(PCC_OFS_STAT, 32'h4, 32'h7);
		r = $urandom | 32'h1;
		bus(1'h0, PCC_OFS_CTRL, r);
		@(negedge clk_sys);
		check({29'h0, pll_mode, pll_run}, {29'h0, r[10:9], r[0]});
		rd(PCC_OFS_CTRL, r, 32'hffff_ffff & 32'h7ff);
		r = $urandom;
		bus(1'h0, PCC_OFS_CNT, r);
		rd(PCC_OFS_CNT, r, 32'hffff);
		bus(1'h0, 4'hc, 32'hffff);
		rd(4'hc, 32'h0, 32'hffff_ffff);
		for (int i = 0; i < 7; i++) begin
			bus(1'h0, PCC_OFS_CTRL, {24'h0, cfgs[i]});
			half(n);
			check(n, halves[i]);
		end
		bus(1'h0, PCC_OFS_CTRL, 32'h0);
		half(n);
		wait_instr <= 1'h1;
		@(posedge clk_sys);
		wait_instr <= 1'h0;
		repeat (80) @(posedge clk_sys);
		irq_accept <= 1'h1;
		check({30'h0, cpu_clk, osc_run}, 32'h3);
		@(posedge clk_sys);
		irq_accept <= 1'h0;
		half(n);
		check(n, 4);
		sleep(n);
		check({31'h0, n >= 16384 && n <= 49152}, 32'h1);
		bus(1'h0, PCC_OFS_CTRL, 32'h100);
		bus(1'h0, PCC_OFS_CNT, 32'h3);
		sleep(n);
		check({31'h0, n >= 128 && n <= 1024}, 32'h1);
		check(32'(exp_q.size()), 32'h0);
		conclude();
	end
endmodule
bind pcc_clock_ctrl pcc_clock_ctrl_props u_props (.clk_sys(clk_sys),
	.rst_n(rst_n), .stop_instr(stop_instr), .ext_irq(ext_irq),
	.osc_run(osc_run), .syn_clk(syn_clk), .usb_clk(usb_clk),
	.cpu_clk(cpu_clk));
`default_nettype wire
